// ---- sttc_pkg.sv ----
// Shared constants of the safety timer and thermistor control register
package sttc_pkg;
    // ********************************************************
    // Register location and layout
    // ********************************************************
    localparam logic [7:0] STTC_REG_ADDR = 8'h07;
    localparam logic [7:0] STTC_RESET_VALUE = 8'h98;
    localparam logic [7:0] STTC_UNMAPPED_READ = 8'h00;
    localparam int STTC_HALF_SPEED_BIT = 7;
    localparam int STTC_LIMIT_HI_BIT = 6;
    localparam int STTC_LIMIT_LO_BIT = 5;
    localparam int STTC_SPARE_BIT = 4;
    localparam int STTC_MONITOR_EN_BIT = 3;
    localparam int STTC_FAULT_HI_BIT = 2;
    localparam int STTC_FAULT_LO_BIT = 1;
    localparam int STTC_HALF_CURRENT_BIT = 0;

    // ********************************************************
    // Field encodings
    // ********************************************************
    localparam logic [1:0] STTC_LIMIT_27_MIN = 2'h0;
    localparam logic [1:0] STTC_LIMIT_6_HOUR = 2'h1;
    localparam logic [1:0] STTC_LIMIT_9_HOUR = 2'h2;
    localparam logic [1:0] STTC_LIMIT_OFF = 2'h3;
    localparam logic [1:0] STTC_FAULT_NONE = 2'h0;
    localparam logic [1:0] STTC_FAULT_COLD_HOT = 2'h1;
    localparam logic [1:0] STTC_FAULT_COOL = 2'h2;
    localparam logic [1:0] STTC_FAULT_WARM = 2'h3;

    // ********************************************************
    // Timing
    // ********************************************************
    localparam int STTC_CLK_PERIOD_NS = 10;
    localparam int STTC_SECOND_NS = 1000000000;
    localparam int STTC_CYCLES_PER_SEC = STTC_SECOND_NS / STTC_CLK_PERIOD_NS;
    localparam int STTC_LIMIT_SHORT_MIN = 27;
    localparam int STTC_LIMIT_MID_HOUR = 6;
    localparam int STTC_LIMIT_LONG_HOUR = 9;
    localparam logic [15:0] STTC_LIMIT_SHORT_SEC =
        16'(STTC_LIMIT_SHORT_MIN * 60);
    localparam logic [15:0] STTC_LIMIT_MID_SEC =
        16'(STTC_LIMIT_MID_HOUR * 3600);
    localparam logic [15:0] STTC_LIMIT_LONG_SEC =
        16'(STTC_LIMIT_LONG_HOUR * 3600);
    localparam int STTC_VREG_REDUCE_MV = 140;
endpackage

// ---- sttc_safety_timer.sv ----
// Fast-charge safety timer with a half-speed mode
`timescale 1ns/1ps
`default_nettype none
module sttc_safety_timer
    import sttc_pkg::*;
#(
    parameter int CYCLES_PER_SEC = STTC_CYCLES_PER_SEC
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic run_i,
    input wire logic restart_i,
    input wire logic slow_i,
    input wire logic [15:0] limit_sec_i,
    output logic expired_o
);
    initial begin
        if (CYCLES_PER_SEC < 2) begin
            $error("CYCLES_PER_SEC must be at least 2");
        end
    end

    logic [31:0] prescale;
    logic [15:0] seconds;
    logic half_phase;
    logic sec_tick;

    assign sec_tick = run_i && (prescale == 32'(CYCLES_PER_SEC - 1));

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prescale <= '0;
        end else if (restart_i || !run_i || sec_tick) begin
            prescale <= '0;
        end else begin
            prescale <= prescale + 32'h1;
        end
    end

    // Slowed mode counts only every second tick, doubling the limit
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            half_phase <= 1'b0;
            seconds <= '0;
        end else if (restart_i) begin
            half_phase <= 1'b0;
            seconds <= '0;
        end else if (sec_tick && seconds != 16'hFFFF) begin
            half_phase <= slow_i ? !half_phase : 1'b0;
            if (!slow_i || half_phase) begin
                seconds <= seconds + 16'h1;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            expired_o <= 1'b0;
        end else if (restart_i) begin
            expired_o <= 1'b0;
        end else if (run_i && seconds >= limit_sec_i) begin
            expired_o <= 1'b1;
        end
    end

    slow_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        sec_tick && slow_i && !half_phase && !restart_i
        |=> $stable(seconds))
        else $error("seconds advanced on skipped half-speed tick");
endmodule // sttc_safety_timer
`default_nettype wire

// ---- sttc_reg.sv ----
// Safety timer and thermistor monitor control and status register
//
// How it works
// - Half-speed bit halves timer under slowing conditions
// - Six conditions slow the timer
// - Half-speed bit clear: timer always normal rate
// - Limit field: 27 min, 6 h, 9 h, off
// - Monitor enable bit gates thermistor sensing, resets one
// - Fault code: none, cold/hot suspend, cool halves
// - Warm zone code 11 lowers voltage 140 mV
// - Half-current bit halves programmed charge current
// - Register at location 07, reset 1001 1xxx
`timescale 1ns/1ps
`default_nettype none
module sttc_reg
    import sttc_pkg::*;
#(
    parameter int CYCLES_PER_SEC = STTC_CYCLES_PER_SEC
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic charge_active_i,
    input wire logic input_current_limit_i,
    input wire logic input_voltage_regulation_i,
    input wire logic thermal_regulation_i,
    input wire logic battery_short_condition_i,
    input wire logic below_cold_threshold_i,
    input wire logic above_hot_threshold_i,
    input wire logic in_cool_zone_i,
    input wire logic in_warm_zone_i,
    output logic timer_slow_o,
    output logic timer_expired_o,
    output logic thermistor_monitor_enable_o,
    output logic charge_suspend_o,
    output logic charge_current_half_o,
    output logic charge_voltage_reduce_o
);
    // ********************************************************
    // Reset release
    // ********************************************************
    logic rst_meta_n;
    logic rst_sync_n;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    // ********************************************************
    // Register fields
    // ********************************************************
    logic timer_half_speed_enable;
    logic [1:0] timer_limit_sel;
    logic spare_bit;
    logic thermistor_monitor_enable;
    logic [1:0] thermistor_fault_code;
    logic half_current_charge;
    logic reg_hit;
    logic [7:0] reg_value;

    assign reg_hit = reg_addr_i == STTC_REG_ADDR;

    // Fault code bits are not written; host data there is dropped
    always_ff @(posedge clock_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            timer_half_speed_enable <= STTC_RESET_VALUE[STTC_HALF_SPEED_BIT];
            timer_limit_sel <=
                STTC_RESET_VALUE[STTC_LIMIT_HI_BIT:STTC_LIMIT_LO_BIT];
            spare_bit <= STTC_RESET_VALUE[STTC_SPARE_BIT];
            thermistor_monitor_enable <=
                STTC_RESET_VALUE[STTC_MONITOR_EN_BIT];
            half_current_charge <= STTC_RESET_VALUE[STTC_HALF_CURRENT_BIT];
        end else if (reg_wr_i && reg_hit) begin
            timer_half_speed_enable <= reg_wdata_i[STTC_HALF_SPEED_BIT];
            timer_limit_sel <=
                reg_wdata_i[STTC_LIMIT_HI_BIT:STTC_LIMIT_LO_BIT];
            spare_bit <= reg_wdata_i[STTC_SPARE_BIT];
            thermistor_monitor_enable <= reg_wdata_i[STTC_MONITOR_EN_BIT];
            half_current_charge <= reg_wdata_i[STTC_HALF_CURRENT_BIT];
        end
    end

    assign reg_value = {timer_half_speed_enable, timer_limit_sel, spare_bit,
        thermistor_monitor_enable, thermistor_fault_code,
        half_current_charge};

    always_ff @(posedge clock_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            reg_rdata_o <= STTC_UNMAPPED_READ;
        end else if (reg_rd_i) begin
            reg_rdata_o <= reg_hit ? reg_value : STTC_UNMAPPED_READ;
        end
    end

    // ********************************************************
    // Thermistor zones
    // ********************************************************
    logic [1:0] next_fault_code;

    // Out-of-range wins over cool, cool over warm
    always_comb begin
        next_fault_code = STTC_FAULT_NONE;
        if (!thermistor_monitor_enable) begin
            next_fault_code = STTC_FAULT_NONE;
        end else if (below_cold_threshold_i || above_hot_threshold_i) begin
            next_fault_code = STTC_FAULT_COLD_HOT;
        end else if (in_cool_zone_i) begin
            next_fault_code = STTC_FAULT_COOL;
        end else if (in_warm_zone_i) begin
            next_fault_code = STTC_FAULT_WARM;
        end
    end

    always_ff @(posedge clock_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            thermistor_fault_code <= STTC_FAULT_NONE;
        end else begin
            thermistor_fault_code <= next_fault_code;
        end
    end

    always_ff @(posedge clock_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            charge_suspend_o <= 1'b0;
            charge_current_half_o <= 1'b0;
            charge_voltage_reduce_o <= 1'b0;
            thermistor_monitor_enable_o <= 1'b1;
        end else begin
            charge_suspend_o <= thermistor_fault_code == STTC_FAULT_COLD_HOT;
            charge_current_half_o <= half_current_charge ||
                thermistor_fault_code == STTC_FAULT_COOL;
            charge_voltage_reduce_o <=
                thermistor_fault_code == STTC_FAULT_WARM;
            thermistor_monitor_enable_o <= thermistor_monitor_enable;
        end
    end

    // ********************************************************
    // Safety timer
    // ********************************************************
    logic slow_cond;
    logic [15:0] limit_sec;
    logic timer_run;
    logic timer_restart;
    logic timer_expired;
    logic charge_prev;
    logic [1:0] limit_prev;

    assign slow_cond = input_current_limit_i || input_voltage_regulation_i
        || thermal_regulation_i || half_current_charge
        || battery_short_condition_i
        || thermistor_fault_code == STTC_FAULT_COOL;

    always_comb begin
        unique case (timer_limit_sel)
            STTC_LIMIT_27_MIN: limit_sec = STTC_LIMIT_SHORT_SEC;
            STTC_LIMIT_6_HOUR: limit_sec = STTC_LIMIT_MID_SEC;
            STTC_LIMIT_9_HOUR: limit_sec = STTC_LIMIT_LONG_SEC;
            STTC_LIMIT_OFF: limit_sec = 16'hFFFF;
        endcase
    end

    assign timer_run = charge_active_i && timer_limit_sel != STTC_LIMIT_OFF;

    // A new charge or a new limit starts the count afresh
    assign timer_restart = (charge_active_i && !charge_prev)
        || timer_limit_sel != limit_prev;

    always_ff @(posedge clock_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            charge_prev <= 1'b0;
            limit_prev <= STTC_RESET_VALUE[STTC_LIMIT_HI_BIT:STTC_LIMIT_LO_BIT];
        end else begin
            charge_prev <= charge_active_i;
            limit_prev <= timer_limit_sel;
        end
    end

    sttc_safety_timer #(
        .CYCLES_PER_SEC(CYCLES_PER_SEC)
    ) u_timer (
        .clock_i(clock_i),
        .rst_n_i(rst_sync_n),
        .run_i(timer_run),
        .restart_i(timer_restart),
        .slow_i(timer_slow_o),
        .limit_sec_i(limit_sec),
        .expired_o(timer_expired)
    );

    always_ff @(posedge clock_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            timer_slow_o <= 1'b0;
            timer_expired_o <= 1'b0;
        end else begin
            timer_slow_o <= timer_half_speed_enable && slow_cond;
            timer_expired_o <= timer_expired &&
                timer_limit_sel != STTC_LIMIT_OFF;
        end
    end

    // ********************************************************
    // Checks
    // ********************************************************
    slow_when_enabled_a: assert property (@(posedge clock_i)
        disable iff (!rst_sync_n)
        timer_half_speed_enable && thermal_regulation_i
        |=> timer_slow_o)
        else $error("timer not slowed under thermal regulation");
    slow_cond_set_a: assert property (@(posedge clock_i)
        disable iff (!rst_sync_n)
        timer_half_speed_enable && battery_short_condition_i
        |=> timer_slow_o)
        else $error("battery short did not slow the timer");
    never_slow_a: assert property (@(posedge clock_i)
        disable iff (!rst_sync_n)
        !timer_half_speed_enable |=> !timer_slow_o)
        else $error("timer slowed while half speed disabled");
    timer_off_a: assert property (@(posedge clock_i)
        disable iff (!rst_sync_n)
        timer_limit_sel == STTC_LIMIT_OFF |=> !timer_expired_o)
        else $error("expiry reported with timers disabled");
    monitor_off_a: assert property (@(posedge clock_i)
        disable iff (!rst_sync_n)
        !thermistor_monitor_enable |=> thermistor_fault_code == 2'h0)
        else $error("fault code set while monitor disabled");
    cold_fault_a: assert property (@(posedge clock_i)
        disable iff (!rst_sync_n)
        thermistor_monitor_enable && below_cold_threshold_i
        |=> thermistor_fault_code == 2'h1 ##1 charge_suspend_o)
        else $error("cold zone not reported or not suspended");
    warm_reduce_a: assert property (@(posedge clock_i)
        disable iff (!rst_sync_n)
        thermistor_fault_code == 2'h3 |=> charge_voltage_reduce_o)
        else $error("warm zone did not lower charge voltage");
    half_current_a: assert property (@(posedge clock_i)
        disable iff (!rst_sync_n)
        half_current_charge |=> charge_current_half_o)
        else $error("half current bit not applied");
    read_value_a: assert property (@(posedge clock_i)
        disable iff (!rst_sync_n)
        reg_rd_i && reg_addr_i == 8'h07
        |=> reg_rdata_o == $past(reg_value))
        else $error("register read returned wrong value");
    spare_store_a: assert property (@(posedge clock_i)
        disable iff (!rst_sync_n)
        reg_wr_i && reg_addr_i == 8'h07
        |=> spare_bit == $past(reg_wdata_i[4]))
        else $error("spare bit did not store written value");
endmodule // sttc_reg
`default_nettype wire

// ---- sttc_host_model.sv ----
// Host processor model issuing register accesses on the strobe port
`timescale 1ns/1ps
`default_nettype none
module sttc_host_model (
    input wire logic clock_i,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o
);
    initial begin
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = 8'hF8;
        reg_wdata_o = 8'h5A;
    end

    // ********************************************************
    // One access: a strobe that spans exactly one rising edge
    // ********************************************************
    task automatic access(input logic wr, input logic [7:0] addr,
                          input logic [7:0] data);
        @(negedge clock_i);
        reg_wr_o = wr;
        reg_rd_o = !wr;
        reg_addr_o = addr;
        reg_wdata_o = data;
        @(negedge clock_i);
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        // Idle lines must not keep looking like the last request
        reg_addr_o = ~addr;
        reg_wdata_o = ~data;
    endtask
endmodule // sttc_host_model
`default_nettype wire

// ---- safety_timer_thermistor_ctrl_test.sv ----
// Self-checking bench of the safety timer and thermistor register
`timescale 1ns/1ps
`default_nettype none
module safety_timer_thermistor_ctrl_test;
    import sttc_pkg::*;
    localparam int CPS = 4;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic wr, rd, charge = 1'b0, rd_pend = 1'b0;
    logic [7:0] addr, wdata, rdata, v;
    logic [3:0] cond = 4'h0;
    logic [3:0] temp = 4'h0;
    logic slow, expd, mon, susp, half, vred;
    logic [7:0] exp_q[$];
    int fails = 0, check_count = 0, seed = 43, n;

    sttc_host_model u_host (.clock_i(clock_i), .reg_wr_o(wr),
        .reg_rd_o(rd), .reg_addr_o(addr), .reg_wdata_o(wdata));
    sttc_reg #(.CYCLES_PER_SEC(CPS)) dut (.clock_i(clock_i),
        .rst_n_i(rst_n_i), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .charge_active_i(charge), .input_current_limit_i(cond[0]),
        .input_voltage_regulation_i(cond[1]),
        .thermal_regulation_i(cond[2]),
        .battery_short_condition_i(cond[3]),
        .below_cold_threshold_i(temp[0]), .above_hot_threshold_i(temp[1]),
        .in_cool_zone_i(temp[2]), .in_warm_zone_i(temp[3]),
        .timer_slow_o(slow), .timer_expired_o(expd),
        .thermistor_monitor_enable_o(mon), .charge_suspend_o(susp),
        .charge_current_half_o(half), .charge_voltage_reduce_o(vred));

    initial begin
        forever #5 clock_i = ~clock_i;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        u_host.access(1'b0, a, 8'h00);
    endtask

    task automatic idle(input int c);
        repeat (c) @(negedge clock_i);
    endtask

    // Time from a charge start to expiry, in cycles
    task automatic time_expiry(input int bound);
        charge = 1'b0;
        idle(2);
        charge = 1'b1;
        idle(4);
        n = 4;
        while (expd !== 1'b1 && n < bound) begin
            idle(1);
            n++;
        end
    endtask

    // ********************************************************
    // Read monitor: oldest note against each answered read
    // ********************************************************
    always @(posedge clock_i) rd_pend <= rd;
    always @(negedge clock_i) begin
        if (rd_pend) begin
            if (exp_q.size() == 0) begin
                fails++;
                $display("[FAIL] %0t read with no expectation", $time);
            end else begin
                check(rdata, exp_q.pop_front());
            end
        end
    end

    initial begin
        idle(2);
        rst_n_i = 1'b1;
        idle(3);
        check(mon, 1'b1);
        rd_exp(STTC_REG_ADDR, STTC_RESET_VALUE);
        rd_exp(8'h06, STTC_UNMAPPED_READ);
        u_host.access(1'b1, 8'h06, 8'hFF);
        rd_exp(STTC_REG_ADDR, STTC_RESET_VALUE);
        $display("test reset and map done");
        v = $random(seed);
        for (int i = 0; i < 12; i++) begin
            v = $random(seed);
            u_host.access(1'b1, STTC_REG_ADDR, v);
            rd_exp(STTC_REG_ADDR, v & 8'hF9);
            check(mon, v[3]);
            check(half, v[0]);
        end
        $display("test field storage done");
        u_host.access(1'b1, STTC_REG_ADDR, 8'h08);
        for (int i = 0; i < 4; i++) begin
            temp = 4'h1 << i;
            idle(3);
            v = (i == 0 || i == 1) ? 8'h02 : (i == 2 ? 8'h04 : 8'h06);
            rd_exp(STTC_REG_ADDR, 8'h08 | v);
            check(susp, v == 8'h02);
            check(half, v == 8'h04);
            check(vred, v == 8'h06);
        end
        temp = 4'h1;
        u_host.access(1'b1, STTC_REG_ADDR, 8'h00);
        idle(3);
        rd_exp(STTC_REG_ADDR, 8'h00);
        check(susp, 1'b0);
        temp = 4'h0;
        $display("test fault codes done");
        for (int i = 0; i < 6; i++) begin
            u_host.access(1'b1, STTC_REG_ADDR, i == 5 ? 8'h89 : 8'h88);
            cond = (i < 4) ? 4'h1 << i : 4'h0;
            temp = (i == 4) ? 4'h4 : 4'h0;
            idle(3);
            check(slow, 1'b1);
            u_host.access(1'b1, STTC_REG_ADDR, i == 5 ? 8'h09 : 8'h08);
            idle(3);
            check(slow, 1'b0);
        end
        temp = 4'h0;
        cond = 4'h0;
        $display("test slowing done");
        u_host.access(1'b1, STTC_REG_ADDR, 8'h08);
        time_expiry(9000);
        check(n >= 1620 * CPS - 10 && n <= 1620 * CPS + 10, 1'b1);
        cond = 4'h4;
        u_host.access(1'b1, STTC_REG_ADDR, 8'h88);
        time_expiry(16000);
        check(n >= 3240 * CPS - 10 && n <= 3240 * CPS + 10, 1'b1);
        cond = 4'h0;
        u_host.access(1'b1, STTC_REG_ADDR, 8'h68);
        time_expiry(7000);
        check(expd, 1'b0);
        $display("test safety timer done");
        idle(2);
        check(8'(exp_q.size()), 8'h00);
        print_verdict();
    end
endmodule // safety_timer_thermistor_ctrl_test
`default_nettype wire
